// ---- hw/ctrc_core.sv ----
// Transmit request handling for message objects 1..14, with cancel race.
// Assumes the protocol engine takes a frame on tx_start and reports
// proto_done or proto_abort exactly once per started frame.
//
// Overview of operation
// RULE_01 - Setting cpu update, clearing transmit request or clearing object valid withdraws an object's pending send.
// RULE_02 - A cancel landing in the handoff cycle is still accepted, but the object's ident, length and data are not loaded.
// RULE_03 - In that race the precharged staging buffer goes out: a remote frame with identifier 0 and length 0.
// RULE_04 - The zero remote frame only happens when the cancelled object is the single active request.
// RULE_05 - A zero remote frame that loses arbitration or hits an error is never retried.
// RULE_06 - Software should not modify an object with a pending request while the init hold bit is 0.
// RULE_07 - To stop a retry, software clears transmit request once the fresh content flag has been cleared.
// RULE_08 - Other nodes should ignore a remote frame with identifier 0 and not answer it.
`timescale 1ns/1ns
`default_nettype none
module ctrc_core
  import ctrc_pkg::*;
#(
  parameter int N = OBJ_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic tx_start,
  output ctrc_frame_s tx_frame,
  input wire logic proto_done,
  input wire logic proto_abort
);
  logic [N:1] valid_reg;
  logic [N:1] transmit_request_flag_reg;
  logic [N:1] cpu_update_flag_reg;
  logic [N:1] fresh_reg;
  ctrc_ident_s ident_mem [1:N];
  logic init_reg;
  logic spur_seen_reg;
  ctrc_state_e state_reg;
  ctrc_state_e state_next;
  logic [IDX_W-1:0] sel_reg;
  logic single_reg;
  logic spurious_reg;
  logic tx_start_reg;
  ctrc_frame_s frame_reg;
  ctrc_frame_s frame_next;
  logic [DATA_W-1:0] rdata_reg;

  // Address decode
  wire [3:0] addr_page = reg_addr[7:4];
  wire [IDX_W-1:0] addr_obj = reg_addr[3:0];
  wire obj_in_range = (addr_obj != '0) && (addr_obj <= IDX_W'(N));
  wire hit_status = (reg_addr == ADDR_STATUS);
  wire hit_ctrl = (addr_page == PAGE_CTRL) && obj_in_range;
  wire hit_ident = (addr_page == PAGE_IDENT) && obj_in_range;
  wire wr_status = reg_wr && hit_status;
  wire wr_ctrl = reg_wr && hit_ctrl;
  wire wr_ident = reg_wr && hit_ident;

  // A control write that withdraws the request of the addressed object
  wire cancel_value = reg_wdata[CTRL_CPU_UPDATE_FLAG_BIT] || !reg_wdata[CTRL_TRANSMIT_REQUEST_FLAG_BIT]
    || !reg_wdata[CTRL_VALID_BIT]; // RULE_01
  wire cancel_sel = wr_ctrl && (addr_obj == sel_reg) && cancel_value;

  // Eligible objects and the pick among them
  wire [N:1] eligible = valid_reg & transmit_request_flag_reg & ~cpu_update_flag_reg; // RULE_01
  wire [IDX_W-1:0] pick_idx;
  wire pick_any;
  wire pick_single;

  ctrc_pick #(
    .N(N)
  ) u_pick (
    .req(eligible),
    .idx(pick_idx),
    .any(pick_any),
    .single(pick_single)
  );

  // Handoff outcome
  wire handoff = (state_reg == ST_HANDOFF);
  // A cancel on the pick edge leaves a stale pick; drop it, never load it
  wire sel_live = eligible[sel_reg]; // RULE_01
  wire race_spurious = handoff && sel_live && cancel_sel && single_reg; // RULE_04
  wire race_drop = handoff && (!sel_live || (cancel_sel && !single_reg)); // RULE_04
  wire load_normal = handoff && sel_live && !cancel_sel;
  wire launch = load_normal || race_spurious; // RULE_02
  wire normal_done = (state_reg == ST_ACTIVE) && proto_done && !spurious_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (pick_any && !init_reg)
        begin
          state_next = ST_HANDOFF;
        end
      end
      ST_HANDOFF:
      begin
        if (race_drop)
        begin
          state_next = ST_IDLE; // RULE_01
        end
        else
        begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        // Aborted spurious frame is dropped; a normal one retries from idle
        if (proto_done || proto_abort)
        begin
          state_next = ST_IDLE; // RULE_05
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Staging buffer: precharge unless the object's content is loaded
  always_comb
  begin
    frame_next.id = PRECHARGE_ID; // RULE_03
    frame_next.dlc = PRECHARGE_DLC; // RULE_03
    frame_next.remote = 1'b1; // RULE_03
    if (load_normal)
    begin
      frame_next.id = ident_mem[sel_reg].id;
      frame_next.dlc = ident_mem[sel_reg].dlc;
      frame_next.remote = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      sel_reg <= '0;
      single_reg <= 1'b0;
      spurious_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE)
      begin
        sel_reg <= pick_idx;
        single_reg <= pick_single;
      end
      if (launch)
      begin
        spurious_reg <= race_spurious; // RULE_05
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_start_reg <= 1'b0;
      frame_reg <= '0;
    end
    else
    begin
      tx_start_reg <= launch; // RULE_02
      if (launch)
      begin
        frame_reg <= frame_next;
      end
    end
  end

  // Per-object flags; a software write wins over the engine's clears
  genvar gi;
  generate
    for (gi = 1; gi <= N; gi++)
    begin : g_obj
      wire wr_this = wr_ctrl && (addr_obj == IDX_W'(gi));
      wire is_sel = (sel_reg == IDX_W'(gi));
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          valid_reg[gi] <= 1'b0;
          transmit_request_flag_reg[gi] <= 1'b0;
          cpu_update_flag_reg[gi] <= 1'b0;
          fresh_reg[gi] <= 1'b0;
        end
        else if (wr_this)
        begin
          valid_reg[gi] <= reg_wdata[CTRL_VALID_BIT];
          transmit_request_flag_reg[gi] <= reg_wdata[CTRL_TRANSMIT_REQUEST_FLAG_BIT];
          cpu_update_flag_reg[gi] <= reg_wdata[CTRL_CPU_UPDATE_FLAG_BIT];
          fresh_reg[gi] <= reg_wdata[CTRL_FRESH_BIT];
        end
        else
        begin
          if (load_normal && is_sel)
          begin
            fresh_reg[gi] <= 1'b0;
          end
          if (normal_done && is_sel)
          begin
            transmit_request_flag_reg[gi] <= 1'b0;
          end
        end
      end
      always_ff @(posedge core_clk)
      begin
        if (wr_ident && (addr_obj == IDX_W'(gi)))
        begin
          ident_mem[gi].id <= reg_wdata[IDENT_ID_LSB +: ID_W];
          ident_mem[gi].dlc <= reg_wdata[IDENT_DLC_LSB +: DLC_W];
        end
      end
    end
  endgenerate

  // Status: init hold and the sticky spurious frame flag (write 1 clears)
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_reg <= INIT_RESET;
      spur_seen_reg <= 1'b0;
    end
    else
    begin
      if (wr_status)
      begin
        init_reg <= reg_wdata[STAT_INIT_BIT];
      end
      if (race_spurious)
      begin
        spur_seen_reg <= 1'b1;
      end
      else if (wr_status && reg_wdata[STAT_SPUR_BIT])
      begin
        spur_seen_reg <= 1'b0;
      end
    end
  end

  // Read mux
  wire [DATA_W-1:0] rd_status = {{(DATA_W-3){1'b0}}, spur_seen_reg,
    (state_reg != ST_IDLE), init_reg};
  wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-4){1'b0}}, fresh_reg[addr_obj],
    cpu_update_flag_reg[addr_obj], transmit_request_flag_reg[addr_obj], valid_reg[addr_obj]};
  wire [DATA_W-1:0] rd_ident = {{(DATA_W-IDENT_DLC_LSB-DLC_W){1'b0}},
    ident_mem[addr_obj].dlc, {(IDENT_DLC_LSB-ID_W){1'b0}}, ident_mem[addr_obj].id};
  wire [DATA_W-1:0] rd_mux = hit_status ? rd_status :
    hit_ctrl ? rd_ctrl :
    hit_ident ? rd_ident : '0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_start = tx_start_reg;
  assign tx_frame = frame_reg;
endmodule // ctrc_core
`default_nettype wire

// ---- hw/ctrc_pkg.sv ----
// Constants and types for the transmit request and cancel block.
// Assumes a plain register port with an 8-bit address and 32-bit data.
package ctrc_pkg;
  localparam int OBJ_COUNT = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ID_W = 11;
  localparam int DLC_W = 4;
  localparam int IDX_W = 4;

  // Register map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [3:0] PAGE_CTRL = 4'h0;
  localparam logic [3:0] PAGE_IDENT = 4'h1;

  // Object control word fields
  localparam int CTRL_VALID_BIT = 0;
  localparam int CTRL_TRANSMIT_REQUEST_FLAG_BIT = 1;
  localparam int CTRL_CPU_UPDATE_FLAG_BIT = 2;
  localparam int CTRL_FRESH_BIT = 3;

  // Object ident word fields
  localparam int IDENT_ID_LSB = 0;
  localparam int IDENT_DLC_LSB = 16;

  // Status word fields
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SPUR_BIT = 2;

  // Reset and precharge values
  localparam logic INIT_RESET = 1'b1;
  localparam logic [ID_W-1:0] PRECHARGE_ID = 11'h000;
  localparam logic [DLC_W-1:0] PRECHARGE_DLC = 4'h0;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DLC_W-1:0] dlc;
    logic remote;
  } ctrc_frame_s;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DLC_W-1:0] dlc;
  } ctrc_ident_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HANDOFF,
    ST_ACTIVE
  } ctrc_state_e;
endpackage

// ---- hw/ctrc_pick.sv ----
// Fixed priority pick of the lowest numbered pending object.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ns
`default_nettype none
module ctrc_pick
  import ctrc_pkg::*;
#(
  parameter int N = OBJ_COUNT
)
(
  input wire logic [N-1:0] req,
  output logic [IDX_W-1:0] idx,
  output logic any,
  output logic single
);
  logic [N-1:0] req_less_one;

  assign req_less_one = req - {{(N-1){1'b0}}, 1'b1};
  assign any = |req;
  assign single = any && ((req & req_less_one) == '0);

  always_comb
  begin
    idx = '0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (req[k])
      begin
        idx = IDX_W'(k + 1);
      end
    end
  end
endmodule // ctrc_pick
`default_nettype wire

// ---- dv/ctrc_core_monitor.sv ----
// Port checker for the transmit request and cancel block.
// Assumes one clock and the block's asynchronous low reset.
`timescale 1ns/1ns
`default_nettype none
module ctrc_core_monitor
  import ctrc_pkg::*;
#(
  parameter int N = OBJ_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic tx_start,
  input wire ctrc_frame_s tx_frame,
  input wire logic proto_done,
  input wire logic proto_abort
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_spur;
    tx_start && tx_frame.remote;
  endsequence
  sequence s_spur_lost;
    tx_frame.remote && proto_abort;
  endsequence
  sequence s_hold;
    reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_INIT_BIT];
  endsequence
  AST_START_PULSE: assert property (tx_start |=> !tx_start)
    else $error("start pulse too long");
  AST_SPUR_FRAME: assert property (s_spur |-> tx_frame == {PRECHARGE_ID, PRECHARGE_DLC, 1'b1})
    else $error("spurious frame not precharged");
  AST_NO_RETRY: assert property (s_spur_lost |=> !tx_start [*6])
    else $error("lost spurious frame resent");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data out of its cycle");
  // Hold can still let an already picked frame out
  AST_HOLD: assert property (s_hold |-> ##3 !tx_start [*4])
    else $error("frame started under hold");
endmodule // ctrc_core_monitor
bind ctrc_core ctrc_core_monitor #(.N(N)) u_mon (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start(tx_start),
  .tx_frame(tx_frame), .proto_done(proto_done), .proto_abort(proto_abort));
`default_nettype wire

// ---- dv/ctrc_node.sv ----
// Model of the other bus nodes: finishes or loses each started frame.
// Assumes tx_start pulses once per frame and frames never overlap.
`timescale 1ns/1ns
`default_nettype none
module ctrc_node
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tx_start,
  input wire logic lose,
  input wire logic slow,
  output logic proto_done,
  output logic proto_abort
);
  logic [3:0] cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 4'h0;
      proto_done <= 1'b0;
      proto_abort <= 1'b0;
    end
    else
    begin
      if (tx_start)
        cnt_reg <= slow ? 4'h9 : 4'h2;
      else if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      // Never answers a zero remote frame with data
      proto_done <= cnt_reg == 4'h1 && !lose;
      proto_abort <= cnt_reg == 4'h1 && lose;
    end
  end
endmodule // ctrc_node
`default_nettype wire

// ---- dv/ctrc_core_test.sv ----
// Self-checking bench for the transmit request and cancel block.
// Assumes the node model answers each started frame once.
`timescale 1ns/1ns
`default_nettype none
module ctrc_core_test
  import ctrc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic lose = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata;
  logic tx_start;
  logic proto_done;
  logic proto_abort;
  ctrc_frame_s tx_frame;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] kinds [3] = '{32'h7, 32'h1, 32'h2};
  always #2 core_clk = ~core_clk;
  ctrc_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start(tx_start), .tx_frame(tx_frame),
    .proto_done(proto_done), .proto_abort(proto_abort));
  ctrc_node u_node (.core_clk(core_clk), .rst_n(rst_n), .tx_start(tx_start), .lose(lose), .slow(slow),
    .proto_done(proto_done), .proto_abort(proto_abort));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", exp, reg_rdata);
  endtask
  task automatic wait_tx(input logic [15:0] exp);
    int n;
    n = 0;
    // Look first: a start launched by the last write may already stand
    #1;
    while (tx_start !== 1'b1 && n < 30)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("start", 32'h1, {31'h0, tx_start});
    chk("frame", {16'h0, exp}, {16'h0, tx_frame});
  endtask
  task automatic no_tx(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      chk("quiet", 32'h0, {31'h0, tx_start});
    end
  endtask
  task automatic t_reset;
    rd(ADDR_STATUS, 32'h1);
    rd(8'h1f, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_normal;
    wr(8'h13, 32'h0004_0123);
    wr(8'h03, 32'h3);
    wr(ADDR_STATUS, 32'h0);
    wait_tx({11'h123, 4'h4, 1'b0});
    no_tx(8);
    rd(8'h03, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    $display("test normal done");
  endtask
  task automatic t_cancel;
    foreach (kinds[i])
    begin
      wr(8'h05, 32'h3);
      wr(8'h05, kinds[i]);
      wr(ADDR_STATUS, 32'h0);
      no_tx(8);
      wr(ADDR_STATUS, 32'h1);
    end
    $display("test cancel done");
  endtask
  task automatic t_race;
    slow <= 1'b1;
    lose <= 1'b1;
    wr(8'h12, 32'h0007_07ff);
    wr(8'h02, 32'h3);
    wr(ADDR_STATUS, 32'h0);
    // Lands exactly in the handoff cycle
    wr(8'h02, 32'h1);
    wait_tx(16'h0001);
    no_tx(20);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'h5);
    rd(ADDR_STATUS, 32'h1);
    $display("test race done");
  endtask
  task automatic t_multi;
    slow <= 1'b0;
    lose <= 1'b0;
    wr(8'h14, 32'h0002_0055);
    wr(8'h02, 32'h3);
    wr(8'h04, 32'h3);
    wr(ADDR_STATUS, 32'h0);
    wr(8'h02, 32'h1);
    wait_tx({11'h055, 4'h2, 1'b0});
    no_tx(8);
    rd(ADDR_STATUS, 32'h0);
    $display("test multi done");
  endtask
  task automatic t_retry;
    slow <= 1'b1;
    lose <= 1'b1;
    wr(ADDR_STATUS, 32'h1);
    wr(8'h16, 32'h0003_0066);
    wr(8'h06, 32'hb);
    wr(ADDR_STATUS, 32'h0);
    wait_tx({11'h066, 4'h3, 1'b0});
    rd(8'h06, 32'h3);
    rd(ADDR_STATUS, 32'h2);
    // Fresh flag seen cleared: withdraw before the lost frame retries
    wr(8'h06, 32'h1);
    no_tx(20);
    rd(8'h06, 32'h1);
    $display("test retry done");
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_normal;
    t_cancel;
    t_race;
    t_multi;
    t_retry;
    wrap_up;
  end
endmodule // ctrc_core_test
`default_nettype wire
